// [port_d_pkg.sv]
// package: register map, field positions, reset values and carrier structs for port d
package port_d_pkg;
    localparam int unsigned WIDTH = 8;
    localparam int unsigned ADDR_W = 4;
    // register indexes on the plain register port
    localparam logic [3:0] ADDR_PIN_DATA = 4'h0;
    localparam logic [3:0] ADDR_LATCH = 4'h1;
    localparam logic [3:0] ADDR_DIRECTION = 4'h2;
    localparam logic [3:0] ADDR_ANALOG = 4'h3;
    localparam logic [3:0] ADDR_CONFIG = 4'h4;
    localparam logic [3:0] ADDR_FUNC_EN = 4'h5;
    // reset values: all inputs, all analog
    localparam logic [7:0] DIRECTION_RST = 8'hFF;
    localparam logic [7:0] ANALOG_RST = 8'hFF;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h20;
    localparam logic [7:0] FUNC_EN_RST = 8'h00;
    localparam logic [7:0] CONFIG_MASK = 8'hBF;
    // pin_config_high field
    localparam int unsigned CFG_EPWM2B_SEL = 5;
    // function enable register fields
    localparam int unsigned FE_SPI2 = 0;
    localparam int unsigned FE_I2C2 = 1;
    localparam int unsigned FE_CAPTURE_COMPARE_CH_FOUR = 2;
    localparam int unsigned FE_EPWM2B = 3;
    localparam int unsigned FE_EPWM2C = 4;
    localparam int unsigned FE_EPWM2D = 5;
    localparam int unsigned FE_EPWM1B = 6;
    // peripheral sources, per pin, in priority order (slot 0 highest unless the pin's PRIORITY_SWAP bit is set)
    localparam int unsigned SLOTS = 2;
    typedef struct packed {
        logic       spi_clock_two;
        logic       i2c_clock_two;
        logic       capture_compare_ch_four;
        logic       i2c_data_two;
        logic       spi_dout_two;
        logic       epwm_two_out_b;
        logic       epwm_two_out_c;
        logic       epwm_two_out_d;
        logic       epwm_one_out_b;
    } periph_out_s;
    typedef struct packed {
        logic       spi_clock_two;
        logic       i2c_clock_two;
        logic       capture_compare_ch_four;
        logic       spi_din_two;
        logic       i2c_data_two;
        logic       spi_select_two;
    } periph_in_s;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;
endpackage

// [pin_driver_select.sv]
// one pin's driver selection: highest priority enabled function wins, else the latch
`timescale 1ns/1ns
`default_nettype none
module pin_driver_select #(
    parameter bit SWAP_PRIORITY = 1'b0
) (
    // enables and values of the two function slots
    input  wire logic [1:0] func_en_in,
    input  wire logic [1:0] func_val_in,
    // latch and direction
    input  wire logic       latch_in,
    input  wire logic       dir_in,
    // selected drive
    output logic            pin_out,
    output logic            pin_oe_out
);
    wire  logic [1:0] en_ord;
    wire  logic [1:0] val_ord;
    assign en_ord     = SWAP_PRIORITY ? {func_en_in[0], func_en_in[1]} : func_en_in;
    assign val_ord    = SWAP_PRIORITY ? {func_val_in[0], func_val_in[1]} : func_val_in;
    assign pin_oe_out = ~dir_in;
    assign pin_out    = en_ord[0] ? val_ord[0] :
                        en_ord[1] ? val_ord[1] : latch_in;
endmodule
`default_nettype wire

// [port_d_gpio.sv]
// port d general purpose io with peripheral pin multiplexing
`timescale 1ns/1ns
`default_nettype none
module port_d_gpio #(
    parameter bit         PORT_PRESENT = 1'b1,
    parameter logic [7:0] PRIORITY_SWAP = 8'h00
) (
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      resetn_in,
    // register port
    input  wire logic [3:0]                reg_addr_in,
    input  wire logic [7:0]                reg_wdata_in,
    input  wire logic                      reg_write_in,
    input  wire logic                      reg_read_in,
    output logic      [7:0]                reg_rdata_out,
    // pins
    input  wire logic [7:0]                pin_in,
    output logic      [7:0]                pin_out,
    output logic      [7:0]                pin_oe_out,
    // peripheral side
    input  wire port_d_pkg::periph_out_s   periph_in,
    output port_d_pkg::periph_in_s         periph_out,
    output logic      [7:0]                analog_en_out,
    output logic                           epwm_two_b_alt_out
);
    logic [7:0] direction_reg_d;
    logic [7:0] output_latch_d;
    logic [7:0] analog_select_d;
    logic [7:0] pin_config_high;
    logic [7:0] func_en;
    logic [7:0] pin_filt;
    logic [7:0] pin_prev;
    logic [7:0] next_filt;
    port_d_pkg::pin_drive_s drive_q;
    port_d_pkg::periph_in_s next_pin_periph;

    wire logic       wr_data;
    wire logic       wr_latch;
    wire logic       wr_dir;
    wire logic       wr_ansel;
    wire logic       wr_cfg;
    wire logic       wr_fe;
    wire logic [7:0] pin_data_reg_d;
    wire logic [7:0] rd_mux;
    wire logic       b_default;
    wire logic [7:0] sel_out;
    wire logic [7:0] sel_oe;
    wire logic [7:0] tri_in;
    wire logic [15:0] slot_en;
    wire logic [15:0] slot_val;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b, input logic s);
        return s && (a == b) && PORT_PRESENT;
    endfunction

    assign wr_data  = hit(reg_addr_in, port_d_pkg::ADDR_PIN_DATA, reg_write_in);
    assign wr_latch = hit(reg_addr_in, port_d_pkg::ADDR_LATCH, reg_write_in);
    assign wr_dir   = hit(reg_addr_in, port_d_pkg::ADDR_DIRECTION, reg_write_in);
    assign wr_ansel = hit(reg_addr_in, port_d_pkg::ADDR_ANALOG, reg_write_in);
    assign wr_cfg   = hit(reg_addr_in, port_d_pkg::ADDR_CONFIG, reg_write_in);
    assign wr_fe    = hit(reg_addr_in, port_d_pkg::ADDR_FUNC_EN, reg_write_in);

    // digital read blocked on analog pins
    assign pin_data_reg_d = pin_filt & ~analog_select_d;

    assign rd_mux =
        !PORT_PRESENT ? 8'h00 :
        (reg_addr_in == port_d_pkg::ADDR_PIN_DATA)  ? pin_data_reg_d :
        (reg_addr_in == port_d_pkg::ADDR_LATCH)     ? output_latch_d :
        (reg_addr_in == port_d_pkg::ADDR_DIRECTION) ? direction_reg_d :
        (reg_addr_in == port_d_pkg::ADDR_ANALOG)    ? analog_select_d :
        (reg_addr_in == port_d_pkg::ADDR_CONFIG)    ? pin_config_high :
        (reg_addr_in == port_d_pkg::ADDR_FUNC_EN)   ? func_en : 8'h00;

    // pwm two b on pin 2 only when config bit clear (alternate pin)
    assign b_default = pin_config_high[port_d_pkg::CFG_EPWM2B_SEL];

    // per pin slots {slot1, slot0}; slot0 highest unless swapped
    assign slot_en[1:0]   = {1'b0, func_en[port_d_pkg::FE_SPI2] | func_en[port_d_pkg::FE_I2C2]};
    assign slot_val[1:0]  = {1'b0, func_en[port_d_pkg::FE_SPI2] ?
                             periph_in.spi_clock_two : periph_in.i2c_clock_two};
    assign slot_en[3:2]   = {func_en[port_d_pkg::FE_I2C2], func_en[port_d_pkg::FE_CAPTURE_COMPARE_CH_FOUR]};
    assign slot_val[3:2]  = {periph_in.i2c_data_two,
                             periph_in.capture_compare_ch_four};
    assign slot_en[5:4]   = {1'b0, func_en[port_d_pkg::FE_EPWM2B] & ~b_default};
    assign slot_val[5:4]  = {1'b0, periph_in.epwm_two_out_b};
    assign slot_en[7:6]   = {1'b0, func_en[port_d_pkg::FE_EPWM2C]};
    assign slot_val[7:6]  = {1'b0, periph_in.epwm_two_out_c};
    assign slot_en[9:8]   = {func_en[port_d_pkg::FE_SPI2], func_en[port_d_pkg::FE_EPWM2D]};
    assign slot_val[9:8]  = {periph_in.spi_dout_two, periph_in.epwm_two_out_d};
    assign slot_en[11:10] = {1'b0, func_en[port_d_pkg::FE_EPWM1B]};
    assign slot_val[11:10] = {1'b0, periph_in.epwm_one_out_b};
    assign slot_en[15:12] = 4'h0;
    assign slot_val[15:12] = 4'h0;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            // analog select does not gate outputs
            pin_driver_select #(
                .SWAP_PRIORITY (PRIORITY_SWAP[g])
            ) u_sel (
                .func_en_in    (slot_en[2*g +: 2]),
                .func_val_in   (slot_val[2*g +: 2]),
                .latch_in      (output_latch_d[g]),
                .dir_in        (direction_reg_d[g]),
                .pin_out       (sel_out[g]),
                .pin_oe_out    (sel_oe[g])
            );
        end
    endgenerate

    // schmitt behaviour: level only changes after two equal samples
    assign next_filt = (pin_in == pin_prev) ? pin_in : pin_filt;
    assign tri_in    = direction_reg_d & ~analog_select_d;

    always_comb begin
        next_pin_periph = '0;
        next_pin_periph.spi_clock_two           = tri_in[0] & pin_filt[0];
        next_pin_periph.i2c_clock_two           = tri_in[0] & pin_filt[0];
        next_pin_periph.capture_compare_ch_four = tri_in[1] & pin_filt[1];
        next_pin_periph.spi_din_two             = ~analog_select_d[1] & pin_filt[1];
        next_pin_periph.i2c_data_two            = tri_in[1] & pin_filt[1];
        // ttl level select: raw sample, no hysteresis
        next_pin_periph.spi_select_two          = tri_in[3] & pin_prev[3];
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            direction_reg_d <= port_d_pkg::DIRECTION_RST;
            analog_select_d <= port_d_pkg::ANALOG_RST;
            output_latch_d  <= port_d_pkg::LATCH_RST;
            pin_config_high <= port_d_pkg::CONFIG_RST;
            func_en         <= port_d_pkg::FUNC_EN_RST;
        end else begin
            if (wr_data || wr_latch) begin
                output_latch_d <= reg_wdata_in;
            end
            if (wr_dir) begin
                direction_reg_d <= reg_wdata_in;
            end
            if (wr_ansel) begin
                analog_select_d <= reg_wdata_in;
            end
            if (wr_cfg) begin
                pin_config_high <= reg_wdata_in & port_d_pkg::CONFIG_MASK;
            end
            if (wr_fe) begin
                func_en <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pin_prev <= 8'h00;
            pin_filt <= 8'h00;
            drive_q  <= '0;
            periph_out <= '0;
            reg_rdata_out <= 8'h00;
            analog_en_out <= 8'h00;
            epwm_two_b_alt_out <= 1'b0;
        end else begin
            pin_prev <= pin_in;
            pin_filt <= next_filt;
            drive_q.out <= PORT_PRESENT ? sel_out : 8'h00;
            drive_q.oe  <= PORT_PRESENT ? sel_oe : 8'h00;
            periph_out <= next_pin_periph;
            reg_rdata_out <= reg_read_in ? rd_mux : 8'h00;
            analog_en_out <= PORT_PRESENT ? analog_select_d : 8'h00;
            epwm_two_b_alt_out <= ~b_default;
        end
    end

    assign pin_out    = drive_q.out;
    assign pin_oe_out = drive_q.oe;
endmodule
`default_nettype wire

// [port_d_gpio_properties.sv]
// checker: register reads, pin drive and pin read properties of port d
`timescale 1ns/1ns
`default_nettype none
module port_d_gpio_checker #(
    parameter bit         PORT_PRESENT  = 1'b1,
    parameter logic [7:0] PRIORITY_SWAP = 8'h00
) (
    // clock and reset
    input wire logic                    clk_in,
    input wire logic                    resetn_in,
    // register port
    input wire logic [3:0]              reg_addr_in,
    input wire logic [7:0]              reg_wdata_in,
    input wire logic                    reg_write_in,
    input wire logic                    reg_read_in,
    input wire logic [7:0]              reg_rdata_out,
    // pins and peripherals
    input wire logic [7:0]              pin_in,
    input wire logic [7:0]              pin_out,
    input wire logic [7:0]              pin_oe_out,
    input wire port_d_pkg::periph_out_s periph_in,
    input wire logic [7:0]              analog_en_out,
    input wire logic                    epwm_two_b_alt_out
);
    // copy of the registers, index is the register address
    logic [7:0] sh [0:7];
    logic [1:0] quiet;
    wire  [7:0] rd_exp = sh[reg_addr_in[2:0]];
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 8; i++) sh[i] <= 8'h00;
            sh[2] <= port_d_pkg::DIRECTION_RST;
            sh[3] <= port_d_pkg::ANALOG_RST;
            sh[4] <= port_d_pkg::CONFIG_RST;
            quiet <= 2'h0;
        end else begin
            quiet <= reg_write_in ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
            if (reg_write_in && reg_addr_in == 4'h0) sh[1] <= reg_wdata_in;
            if (reg_write_in && reg_addr_in inside {[4'h1:4'h5]}) sh[reg_addr_in[2:0]] <=
                reg_wdata_in & (reg_addr_in == 4'h4 ? port_d_pkg::CONFIG_MASK : 8'hFF);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    chk_rdata_idle_zero: assert property (
        !$past(reg_read_in) |-> reg_rdata_out == 8'h00) else $error("read data not zero");
    chk_reg_readback: assert property (
        reg_read_in && reg_addr_in inside {[4'h1:4'h5]} |=> reg_rdata_out == $past(rd_exp))
        else $error("register read differs");
    chk_unmapped_zero: assert property (
        reg_read_in && reg_addr_in > 4'h5 |=> reg_rdata_out == 8'h00) else $error("unmapped read");
    chk_dir_gates_oe: assert property (
        quiet == 2'h3 |-> pin_oe_out == ~sh[2]) else $error("enable differs from direction");
    chk_latch_drives_pin: assert property (
        quiet == 2'h3 && sh[5] == 8'h00 |-> (pin_out & pin_oe_out) == (sh[1] & ~sh[2]))
        else $error("pin not from latch");
    chk_analog_mirror: assert property (
        quiet == 2'h3 |-> analog_en_out == sh[3]) else $error("analog enable differs");
    chk_alt_pin_select: assert property (
        quiet == 2'h3 |-> epwm_two_b_alt_out == !sh[4][5]) else $error("alternate select wrong");
    chk_pwm_one_b_pin: assert property (
        quiet == 2'h3 && sh[5][port_d_pkg::FE_EPWM1B] && !sh[2][5]
        |-> pin_out[5] == $past(periph_in.epwm_one_out_b)) else $error("pin 5 not pwm one b");
    chk_pin_read_masked: assert property (
        $stable(pin_in) [*4] ##0 (reg_read_in && reg_addr_in == 4'h0)
        |=> reg_rdata_out == ($past(pin_in) & ~$past(sh[3]))) else $error("pin read wrong");
    cover property (reg_read_in && reg_addr_in == 4'h0 && sh[3] != 8'hFF);
    cover property (quiet == 2'h3 && sh[5][port_d_pkg::FE_CAPTURE_COMPARE_CH_FOUR] && pin_oe_out[1]);
    cover property (quiet == 2'h3 && !sh[4][5] && sh[5][port_d_pkg::FE_EPWM2B]);
endmodule
bind port_d_gpio port_d_gpio_checker #(.PORT_PRESENT(PORT_PRESENT), .PRIORITY_SWAP(PRIORITY_SWAP))
    chk_i (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
    .reg_rdata_out, .pin_in, .pin_out, .pin_oe_out, .periph_in, .analog_en_out, .epwm_two_b_alt_out);
`default_nettype wire

// [board_pins.sv]
// board model: levels seen at the port d pins
`timescale 1ns/1ns
`default_nettype none
module board_pins (
    // port side
    input  wire logic [7:0] pin_out_in,
    input  wire logic [7:0] pin_oe_in,
    // board side
    input  wire logic [7:0] ext_in,
    output logic      [7:0] level_out
);
    // driven pins follow the port, released pins follow the board
    assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_in);
endmodule
`default_nettype wire

// [port_d_gpio_with_pin_mux_tb.sv]
// testbench: port d registers, drive priority and pin reads
`timescale 1ns/1ns
`default_nettype none
module port_d_gpio_with_pin_mux_tb;
    typedef struct packed {
        logic [7:0] fen, cfg, dir, ana;
        logic [8:0] per;
        logic [7:0] out, oe;
    } row_s;
    logic                    clk_in = 1'b0, resetn_in = 1'b0;
    logic                    reg_write_in = 1'b0, reg_read_in = 1'b0, epwm_two_b_alt_out;
    logic [3:0]              reg_addr_in = 4'h0;
    logic [7:0]              reg_wdata_in = 8'h00, ext = 8'h5A, level;
    logic [7:0]              reg_rdata_out, pin_out, pin_oe_out, analog_en_out;
    port_d_pkg::periph_out_s per = '0;
    port_d_pkg::periph_in_s  fn;
    int                      n_fail = 0, num_checks = 0;
    logic [7:0]              rst_v [7] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h20, 8'h00, 8'h00};
    row_s rows [6] = '{'{8'h00, 8'h20, 8'h00, 8'h00, 9'h0D2, 8'hA5, 8'hFF},
        '{8'h7F, 8'h00, 8'h00, 8'hFF, 9'h0D2, 8'h92, 8'hFF}, '{8'h7F, 8'h20, 8'h00, 8'h00, 9'h0D2,
        8'h96, 8'hFF}, '{8'h7F, 8'h00, 8'hF0, 8'h00, 9'h0D2, 8'h02, 8'h0F}, '{8'h02, 8'h20, 8'h00,
        8'h00, 9'h0A0, 8'hA7, 8'hFF}, '{8'h01, 8'h20, 8'h00, 8'h00, 9'h0FF, 8'hB4, 8'hFF}};
    always #5 clk_in = ~clk_in;
    port_d_gpio uut (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
        .reg_rdata_out, .pin_in(level), .pin_out, .pin_oe_out, .periph_in(per), .periph_out(fn),
        .analog_en_out, .epwm_two_b_alt_out);
    board_pins board (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .ext_in(ext), .level_out(level));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        #1 chk("rdata", reg_rdata_out, e);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task automatic complete_run;
        if (n_fail == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_in);
        n_fail++;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        for (int a = 0; a < 7; a++) rd(a[3:0], rst_v[a]);
        chk("oe", pin_oe_out, 8'h00);
        wr(port_d_pkg::ADDR_LATCH, 8'hA5);
        foreach (rows[i]) begin
            @(posedge clk_in);
            per <= rows[i].per;
            wr(port_d_pkg::ADDR_FUNC_EN, rows[i].fen);
            wr(port_d_pkg::ADDR_CONFIG, rows[i].cfg);
            wr(port_d_pkg::ADDR_DIRECTION, rows[i].dir);
            wr(port_d_pkg::ADDR_ANALOG, rows[i].ana);
            settle;
            chk("drive", pin_out & pin_oe_out, rows[i].out);
            chk("oe", pin_oe_out, rows[i].oe);
            chk("analog", analog_en_out, rows[i].ana);
            chk("alt", {7'h00, epwm_two_b_alt_out}, {7'h00, ~rows[i].cfg[5]});
        end
        wr(port_d_pkg::ADDR_FUNC_EN, 8'h00);
        wr(port_d_pkg::ADDR_DIRECTION, 8'hFF);
        wr(port_d_pkg::ADDR_PIN_DATA, 8'h3C);
        settle;
        rd(port_d_pkg::ADDR_LATCH, 8'h3C);
        rd(port_d_pkg::ADDR_PIN_DATA, 8'h5A);
        chk("spi_din", {7'h00, fn.spi_din_two}, 8'h01);
        wr(port_d_pkg::ADDR_ANALOG, 8'h0F);
        settle;
        rd(port_d_pkg::ADDR_PIN_DATA, 8'h50);
        chk("spi_din", {7'h00, fn.spi_din_two}, 8'h00);
        wr(port_d_pkg::ADDR_CONFIG, 8'hFF);
        rd(port_d_pkg::ADDR_CONFIG, 8'hBF);
        wr(4'hF, 8'h55);
        rd(4'hF, 8'h00);
        rd(port_d_pkg::ADDR_LATCH, 8'h3C);
        wr(port_d_pkg::ADDR_DIRECTION, 8'h00);
        settle;
        chk("drive", pin_out, 8'h3C);
        rd(port_d_pkg::ADDR_PIN_DATA, 8'h30);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1 chk("oe", pin_oe_out, 8'h00);
        rd(port_d_pkg::ADDR_DIRECTION, 8'hFF);
        complete_run;
    end
endmodule
`default_nettype wire
